// File: rtl/mdsd_defines.svh
`ifndef MDSD_DEFINES_SVH
`define MDSD_DEFINES_SVH

// master tick period in ns, and 4 ns system clock
`define MDSD_CLK_PERIOD_NS     4
`define MDSD_MASTER_PERIOD_NS  1500000
`define MDSD_MASTER_CYCLES     (`MDSD_MASTER_PERIOD_NS / `MDSD_CLK_PERIOD_NS)
`define MDSD_SLOTS             6
`define MDSD_DIGITS            5
`define MDSD_BCD_MAX           4'h9
`define MDSD_SAMPLE_MIN_MS     100
`define MDSD_SAMPLE_MAX_MS     3000
`define MDSD_EXT_MIN_MS        25
`define MDSD_CYCLES_PER_MS     250000

`endif

// File: rtl/mdsd_pkg.sv
package mdsd_pkg;
  typedef enum logic [2:0] {
    SLOT_ZERO,
    SLOT_A,
    SLOT_B,
    SLOT_C,
    SLOT_D,
    SLOT_E
  } mdsd_slot_e;

  typedef struct packed {
    logic [1:0] func;
    logic [1:0] range;
  } mdsd_sel_s;

  typedef struct packed {
    logic [20:0] tick_cnt;
    logic        phase;
    mdsd_slot_e  slot;
    logic [3:0]  count;
    logic [4:0][3:0] latched;
  } mdsd_dummy_s;
endpackage

// File: rtl/mdsd_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "mdsd_defines.svh"

// Contract
// R1: display timing from one 666 Hz tick; sample intervals counted in clock cycles
// R2: six periods: auto-zero then five digits
// R3: sixteen-state counter gives 1-2-4-8 BCD digit
// R4: oscillator pulses counted only when comparator high
// R5: each tube lit one slot per cycle
// R6: BCD decoded to one-of-ten shared digit lines
// R7: anode enable is digit period and phase
// R8: internal interval 3 s..100 ms, external 25 ms
// R9: manual selection beats auto ranging
// R10: zero pulse drives offset null only in auto-zero
// R11: toggle gives complementary half-period phases
// R12: advance one state per tick, wrap, one-hot
module mdsd_top
  import mdsd_pkg::*;
#(
  parameter int unsigned MASTER_CYCLES = `MDSD_MASTER_CYCLES,
  parameter int unsigned MS_CYCLES     = `MDSD_CYCLES_PER_MS
)(
  input  wire logic            clk_sys_in,
  input  wire logic            nrst_in,
  input  wire logic            osc_pulse_in,
  input  wire logic            comp_above_in,
  input  wire logic [11:0]     interval_ms_in,
  input  wire logic            ext_trig_in,
  input  wire logic            ext_mode_in,
  input  wire logic            manual_valid_in,
  input  wire mdsd_sel_s       manual_sel_in,
  input  wire logic            auto_valid_in,
  input  wire mdsd_sel_s       auto_sel_in,
  output logic                 auto_zero_out,
  output logic [5:0]           period_out,
  output logic                 phase_out,
  output logic                 phase_n_out,
  output logic [9:0]           digit_line_out,
  output logic [4:0]           anode_en_out,
  output logic [3:0]           bcd_out,
  output logic                 sample_out,
  output mdsd_sel_s            sel_out
);

  typedef struct packed {
    logic [31:0] tick_cnt;
    logic        tick;
    logic        phase;
    mdsd_slot_e  slot;
    logic [3:0]  count;
    logic [3:0]  bcd;
    logic [31:0] smp_cnt;
    logic [31:0] ext_cnt;
    logic        sample;
    mdsd_sel_s   sel;
    logic [2:0]  osc_sync;
    logic [1:0]  comp_sync;
    logic [2:0]  trig_sync;
  } mdsd_state_s;

  mdsd_state_s st_q;
  mdsd_state_s st_d;

  function automatic logic [9:0] dec10(input logic [3:0] v);
    dec10 = (v <= `MDSD_BCD_MAX) ? (10'h001 << v) : 10'h000;
  endfunction

  logic [31:0] interval_cyc;
  logic [11:0] ivl_clamped;

  always_comb
  begin
    ivl_clamped = interval_ms_in;
    if (ivl_clamped < 12'(`MDSD_SAMPLE_MIN_MS))
      ivl_clamped = 12'(`MDSD_SAMPLE_MIN_MS);
    if (ivl_clamped > 12'(`MDSD_SAMPLE_MAX_MS))
      ivl_clamped = 12'(`MDSD_SAMPLE_MAX_MS);
    interval_cyc = 32'(ivl_clamped) * MS_CYCLES; // R8
  end

  always_comb
  begin
    st_d           = st_q;
    st_d.tick      = 1'b0;
    st_d.sample    = 1'b0;
    // only the second and third stages feed logic
    st_d.osc_sync  = {st_q.osc_sync[1:0], osc_pulse_in};
    st_d.comp_sync = {st_q.comp_sync[0], comp_above_in};
    st_d.trig_sync = {st_q.trig_sync[1:0], ext_trig_in};
    if (st_q.tick_cnt >= MASTER_CYCLES - 1) // R1
    begin
      st_d.tick_cnt = '0;
      st_d.tick     = 1'b1;
    end
    else
      st_d.tick_cnt = st_q.tick_cnt + 32'h1;
    // phase toggles twice per period so each slot splits in halves
    if (st_q.tick_cnt == (MASTER_CYCLES / 2) - 1 || st_d.tick)
      st_d.phase = ~st_q.phase; // R11
    if (st_d.tick)
    begin
      if (st_q.slot >= 3'(`MDSD_SLOTS - 1))
        st_d.slot = SLOT_ZERO; // R12
      else
        st_d.slot = mdsd_slot_e'(st_q.slot + 3'h1); // R2
      if (st_q.slot != SLOT_ZERO)
        st_d.bcd = st_q.count; // R3
      st_d.count = '0;
    end
    else if (st_q.osc_sync[1] & ~st_q.osc_sync[2] & st_q.comp_sync[1])
      st_d.count = st_q.count + 4'h1; // R4
    if (ext_mode_in)
    begin
      if (st_q.ext_cnt != '0)
        st_d.ext_cnt = st_q.ext_cnt - 32'h1;
      else if (st_q.trig_sync[1] & ~st_q.trig_sync[2])
      begin
        st_d.sample  = 1'b1;
        st_d.ext_cnt = 32'(`MDSD_EXT_MIN_MS) * MS_CYCLES; // R8
      end
    end
    else if (st_q.smp_cnt >= interval_cyc - 32'h1)
    begin
      st_d.smp_cnt = '0;
      st_d.sample  = 1'b1;
    end
    else
      st_d.smp_cnt = st_q.smp_cnt + 32'h1;
    if (manual_valid_in)
      st_d.sel = manual_sel_in; // R9
    else if (auto_valid_in)
      st_d.sel = auto_sel_in;
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  always_comb
  begin
    period_out     = 6'h01 << st_q.slot; // R12
    auto_zero_out  = (st_q.slot == SLOT_ZERO); // R10
    phase_out      = st_q.phase;
    phase_n_out    = ~st_q.phase; // R11
    bcd_out        = st_q.bcd;
    digit_line_out = dec10(st_q.bcd); // R6
    anode_en_out   = period_out[5:1] & {5{st_q.phase}}; // R5 R7
    sample_out     = st_q.sample;
    sel_out        = st_q.sel;
  end

endmodule

`default_nettype wire

// File: test/mdsd_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mdsd_chk
  import mdsd_pkg::*;
(
  input wire logic       clk_sys_in,
  input wire logic       nrst_in,
  input wire logic       manual_valid_in,
  input wire mdsd_sel_s  manual_sel_in,
  input wire logic       auto_zero_out,
  input wire logic [5:0] period_out,
  input wire logic       phase_out,
  input wire logic       phase_n_out,
  input wire logic [4:0] anode_en_out,
  input wire mdsd_sel_s  sel_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!nrst_in);
  property p_hot; $onehot(period_out); endproperty
  a_hot: assert property (p_hot) else $error("slot");
  property p_az; auto_zero_out == period_out[0]; endproperty
  a_az: assert property (p_az) else $error("zero");
  property p_ph; phase_n_out != phase_out; endproperty
  a_ph: assert property (p_ph) else $error("phase");
  property p_an; anode_en_out == (period_out[5:1] & {5{phase_out}});
  endproperty
  a_an: assert property (p_an) else $error("anode");
  property p_adv; $changed(period_out) |->
    period_out == {$past(period_out[4:0]), $past(period_out[5])};
  endproperty
  a_adv: assert property (p_adv) else $error("order");
  property p_hold; $changed(period_out) |=> $stable(period_out)[*8];
  endproperty
  a_hold: assert property (p_hold) else $error("tick");
  property p_tog; $changed(phase_out) |=> $stable(phase_out)[*8];
  endproperty
  a_tog: assert property (p_tog) else $error("half");
  property p_man; manual_valid_in |=> sel_out == $past(manual_sel_in);
  endproperty
  a_man: assert property (p_man) else $error("sel");
endmodule
bind mdsd_top mdsd_chk u_chk (.*);
`default_nettype wire

// File: test/mdsd_osc_model.sv
`timescale 1ns/1ps
`default_nettype none
module mdsd_osc_model (
  input  wire logic       go_in,
  input  wire logic [3:0] n_in,
  output logic            osc_out = 0,
  output logic            comp_out = 0
);
  always @(posedge go_in)
  begin
    comp_out = 1;
    repeat (2 * n_in) #8 osc_out = !osc_out;
    #8 comp_out = 0;
    repeat (4) #8 osc_out = !osc_out;
  end
endmodule
`default_nettype wire

// File: test/meter_digit_sequencer_display_bench.sv
`timescale 1ns/1ps
`default_nettype none
module meter_digit_sequencer_display_bench;
  import mdsd_pkg::*;
  logic        clk_sys_in = 0, nrst_in = 0, go = 0, ext_trig_in = 0;
  logic        manual_valid_in = 0, auto_valid_in = 0, ext_mode_in = 0;
  logic        osc_pulse_in, comp_above_in, sample_out;
  logic        auto_zero_out, phase_out, phase_n_out;
  logic [11:0] interval_ms_in = '0;
  mdsd_sel_s   manual_sel_in = '0, auto_sel_in = '0, sel_out;
  logic [5:0]  period_out;
  logic [9:0]  digit_line_out;
  logic [4:0]  anode_en_out;
  logic [3:0]  bcd_out, n;
  int          seed = 24, failures = 0, compares = 0, c[6];
  realtime     t;
  wire logic [5:0] lit = {anode_en_out, auto_zero_out};
  always #2 clk_sys_in = !clk_sys_in;
  mdsd_top #(.MASTER_CYCLES(60), .MS_CYCLES(10)) dut (.*);
  mdsd_osc_model far (.go_in(go), .n_in(n), .osc_out(osc_pulse_in),
    .comp_out(comp_above_in));
  function int gap(input int ms);
    return (ms < 100 ? 100 : ms > 3000 ? 3000 : ms) * 10;
  endfunction
  task chk(input logic [15:0] seen, exp, input string what);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task give_verdict;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    #80000 failures++;
    give_verdict;
  end
  initial
  begin
    repeat (5) @(negedge clk_sys_in);
    nrst_in = 1;
    for (int i = 0; i < 12; i++)
    begin
      @(period_out);
      @(negedge clk_sys_in);
      n = i ? 4'({$random(seed)} % 10) : 4'h9;
      go = !period_out[0];
      @(period_out);
      repeat (2) @(negedge clk_sys_in);
      if (go) chk(bcd_out, n, "bcd");
      if (go) chk(digit_line_out, 10'h001 << n, "line");
      go = 0;
    end
    $display("digits done");
    c = '{default: 0};
    repeat (360)
    begin
      @(negedge clk_sys_in);
      for (int j = 0; j < 6; j++) c[j] += lit[j];
    end
    for (int j = 0; j < 6; j++) chk(c[j], j ? 30 : 60, "lit");
    $display("strobe done");
    for (int k = 0; k < 2; k++)
    begin
      @(negedge clk_sys_in);
      interval_ms_in = k ? 12'h0C8 : 12'h000;
      repeat (2) @(posedge sample_out);
      t = $realtime;
      @(posedge sample_out);
      chk(16'(($realtime - t) / 4), gap(interval_ms_in), "gap");
    end
    $display("sample done");
    @(negedge clk_sys_in);
    ext_mode_in = 1;
    // second trigger falls inside the 25 ms hold-off and must be dropped
    for (int m = 0; m < 3; m++)
    begin
      c[0] = 0;
      ext_trig_in = 1;
      repeat (8)
      begin
        @(negedge clk_sys_in);
        c[0] += sample_out;
      end
      ext_trig_in = 0;
      chk(c[0], (m == 1) ? 0 : 1, "ext");
      repeat (m ? 192 : 92) @(negedge clk_sys_in);
    end
    ext_mode_in = 0;
    $display("external done");
    @(negedge clk_sys_in);
    manual_sel_in = 4'($random(seed));
    auto_sel_in = ~manual_sel_in;
    {manual_valid_in, auto_valid_in} = 2'b11;
    @(negedge clk_sys_in);
    chk(sel_out, manual_sel_in, "sel");
    manual_valid_in = 0;
    repeat (2) @(negedge clk_sys_in);
    chk(sel_out, auto_sel_in, "auto");
    $display("select done");
    give_verdict;
  end
endmodule
`default_nettype wire
